// [rtl/fan_pwm_pkg.sv]
package fan_pwm_pkg;

  // ---------------------------------------------------------------
  // Register map (byte offsets on the plain register port)
  // ---------------------------------------------------------------
  localparam logic [1:0] OFS_PRESCALE = 2'h0;
  localparam logic [1:0] OFS_DUTY = 2'h1;
  localparam logic [1:0] OFS_CONTROL = 2'h2;
  localparam logic [1:0] OFS_STATUS = 2'h3;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int PSC_SEL_BIT = 7;
  localparam int PSC_VAL_MSB = 6;
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_INV_BIT = 1;
  localparam logic [7:0] PRESCALE_RST = 8'h00;
  localparam logic [7:0] DUTY_RST = 8'hff;
  localparam logic [1:0] CONTROL_RST = 2'h0;
  localparam logic [7:0] DUTY_FULL = 8'hff;

  // ---------------------------------------------------------------
  // Timing: source clocks made as tick enables of the core clock
  // ---------------------------------------------------------------
  localparam int CORE_CLK_KHZ = 40_000;
  localparam int SRC_FAST_KHZ = 24_000;
  localparam int SRC_SLOW_KHZ = 200;
  localparam logic [6:0] FAST_STEP = 7'(SRC_FAST_KHZ / 1000);
  localparam logic [6:0] FAST_MOD = 7'(CORE_CLK_KHZ / 1000);
  localparam logic [7:0] SLOW_DIV_LAST = 8'(CORE_CLK_KHZ / SRC_SLOW_KHZ - 1);

endpackage

// [rtl/fan_pwm_speed_control.sv]
// What this block does
// - Free-running 8-bit counter, 256-step period
// - Output high while counter below duty
// - Duty zero low, duty all-ones high
// - Inversion bit flips the fan drive
// - Counter clocked from divided 24M/200k source
// - Divide factor is prescale field plus one
// - Frequency is source over factor times 256
// - Reset selects the 24 MHz source
module fan_pwm_speed_control
  import fan_pwm_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic fan_drive_out_o
);

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [7:0] prescale_r, prescale_nxt;
  logic [7:0] duty_r, duty_nxt;
  logic [1:0] control_r, control_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [CNT_W-1:0] cnt_r;

  // Writes store, reads answer one cycle later; status reads the counter, cycles without a read give zero
  always_comb begin
    prescale_nxt = prescale_r;
    duty_nxt = duty_r;
    control_nxt = control_r;
    rdata_nxt = 8'h00;
    if (reg_wr_i) begin
      case (reg_addr_i)
        OFS_PRESCALE: prescale_nxt = reg_wdata_i;
        OFS_DUTY: duty_nxt = reg_wdata_i;
        OFS_CONTROL: control_nxt = reg_wdata_i[1:0];
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        OFS_PRESCALE: rdata_nxt = prescale_r;
        OFS_DUTY: rdata_nxt = duty_r;
        OFS_CONTROL: rdata_nxt = {6'h00, control_r};
        OFS_STATUS: rdata_nxt = 8'(cnt_r);
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      prescale_r <= PRESCALE_RST;
      duty_r <= DUTY_RST;
      control_r <= CONTROL_RST;
      rdata_r <= 8'h00;
    end else begin
      prescale_r <= prescale_nxt;
      duty_r <= duty_nxt;
      control_r <= control_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;

  logic en, inv, sel_slow;
  logic [6:0] psc_val;
  assign en = control_r[CTL_EN_BIT];
  assign inv = control_r[CTL_INV_BIT];
  assign sel_slow = prescale_r[PSC_SEL_BIT];
  assign psc_val = prescale_r[PSC_VAL_MSB:0];

  // ---------------------------------------------------------------
  // Source ticks
  // ---------------------------------------------------------------
  logic [6:0] fast_acc_r, fast_acc_nxt;
  logic [7:0] slow_cnt_r, slow_cnt_nxt;
  logic fast_tick, slow_tick, src_tick;
  logic [6:0] fast_sum;

  // 24 MHz is not a divisor of the core rate, so a fractional
  // accumulator gives the right average rate with a little jitter
  always_comb begin
    fast_sum = fast_acc_r + FAST_STEP;
    fast_tick = (fast_sum >= FAST_MOD);
    fast_acc_nxt = fast_tick ? fast_sum - FAST_MOD : fast_sum;
    slow_tick = (slow_cnt_r == SLOW_DIV_LAST);
    slow_cnt_nxt = slow_tick ? 8'h00 : slow_cnt_r + 8'h01;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      fast_acc_r <= 7'h00;
      slow_cnt_r <= 8'h00;
    end else begin
      fast_acc_r <= fast_acc_nxt;
      slow_cnt_r <= slow_cnt_nxt;
    end
  end

  assign src_tick = sel_slow ? slow_tick : fast_tick;

  // ---------------------------------------------------------------
  // Prescaler and counter
  // ---------------------------------------------------------------
  logic [6:0] div_r, div_nxt;
  logic [CNT_W-1:0] cnt_nxt;
  logic cnt_step;
  logic out_r, out_nxt;
  logic pwm;

  // Held at zero while disabled so each run starts on a clean period
  always_comb begin
    cnt_step = src_tick && (div_r == psc_val);
    div_nxt = div_r;
    cnt_nxt = cnt_r;
    if (!en) begin
      div_nxt = 7'h00;
      cnt_nxt = '0;
    end else if (src_tick) begin
      div_nxt = cnt_step ? 7'h00 : div_r + 7'h01;
      if (cnt_step) begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
    pwm = (cnt_r < CNT_W'(duty_r)) || (duty_r == DUTY_FULL);
    out_nxt = en ? (pwm ^ inv) : 1'b0;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      div_r <= 7'h00;
      cnt_r <= '0;
      out_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign fan_drive_out_o = out_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_CNT_WRAP: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    en && cnt_step && (cnt_r == '1) |=> (cnt_r == '0))
    else $error("counter did not wrap to zero");

  AST_HIGH_BELOW: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    en && !inv && (cnt_r < CNT_W'(duty_r)) |=> fan_drive_out_o)
    else $error("output low while count below duty");

  AST_LOW_ABOVE: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    en && !inv && (cnt_r >= CNT_W'(duty_r)) && (duty_r != DUTY_FULL) |=> !fan_drive_out_o)
    else $error("output high while count at or above duty");

  AST_DUTY_ZERO: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    en && !inv && (duty_r == 8'h00) |=> !fan_drive_out_o)
    else $error("zero duty drove output high");

  AST_DUTY_FULL: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    en && !inv && (duty_r == DUTY_FULL) |=> fan_drive_out_o)
    else $error("full duty drove output low");

  AST_INVERT: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    en && inv && (cnt_r < CNT_W'(duty_r)) |=> !fan_drive_out_o)
    else $error("inverted output not low below duty");

  AST_INVERT_ABOVE: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    en && inv && (cnt_r >= CNT_W'(duty_r)) && (duty_r != DUTY_FULL) |=> fan_drive_out_o)
    else $error("inverted output not high above duty");

  AST_FAST_GAP: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !fast_tick |=> fast_tick)
    else $error("fast source skipped two ticks");

  AST_SLOW_SPACING: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    slow_tick |=> !slow_tick [*8])
    else $error("slow source ticks too close");

  AST_DIV_HOLD: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    en && src_tick && (div_r < psc_val) |=> (cnt_r == $past(cnt_r)))
    else $error("counter moved before divider end");

  AST_DIV_STEP: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    en && src_tick && (div_r == psc_val) |=> (cnt_r == CNT_W'($past(cnt_r) + 1'b1)))
    else $error("counter missed its divided step");

  AST_RESET_SEL: assert property (@(posedge core_clk_i)
    !rstn_i |=> !prescale_r[PSC_SEL_BIT] && (duty_r == DUTY_RST))
    else $error("reset did not select fast source");

  AST_IDLE_ZERO: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !en |=> (cnt_r == '0) && (div_r == 7'h00) && !fan_drive_out_o)
    else $error("idle counter or output not cleared");

  COV_WRAP: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
    en && cnt_step && (cnt_r == '1));
  COV_MID_DUTY: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
    en && (duty_r == 8'h80) && fan_drive_out_o ##1 !fan_drive_out_o);
  COV_DUTY_ZERO: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
    en && !inv && (duty_r == 8'h00));
  COV_INVERT: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
    en && inv && fan_drive_out_o);
  COV_SLOW: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
    en && sel_slow && cnt_step);

endmodule

// [dv/fan_load_model.sv]
// ---------------------------------------------------------------
// Fan load: integrates the drive level over a window
// ---------------------------------------------------------------
module fan_load_model (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic drive_i,
  output logic [31:0] high_cycles_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // A real fan only averages the level, so a count of high cycles suffices
  always_ff @(posedge clk_i) begin
    if (clr_i) begin
      high_cycles_o <= 32'h0;
    end else begin
      high_cycles_o <= high_cycles_o + 32'(drive_i);
    end
  end
endmodule

// [dv/fan_pwm_speed_control_tb.sv]
module fan_pwm_speed_control_tb import fan_pwm_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // Stimulus state and expected cases
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic clr = 1'b0;
  logic [7:0] rdata;
  logic fan;
  logic [31:0] hi;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  // Prescale codes kept small: a window must cover three fast periods
  logic [7:0] psc [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h80};
  logic [7:0] duty [8] = '{8'h80, 8'h00, 8'hff, 8'h01, 8'h40, 8'hff, 8'h40, 8'h02};
  logic [1:0] ctl [8] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h3, 2'h3, 2'h2, 2'h1};

  always #12.5 clk = ~clk;

  fan_pwm_speed_control #(.CNT_W(8)) uut (
    .core_clk_i(clk), .rstn_i(rstn), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .fan_drive_out_o(fan)
  );

  fan_load_model fan_load (.clk_i(clk), .clr_i(clr), .drive_i(fan), .high_cycles_o(hi));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
      num_errors++;
    end
  endtask

  // Each task starts on a fresh edge so no strobe is assigned twice at once
  task automatic wr_reg(logic [1:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(logic [1:0] a, logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", 32'(rdata), 32'(exp));
  endtask

  task automatic meas(int n, logic [31:0] exp);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
    chk("high_cycles", hi, exp);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard: the slow-source window dominates the run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin : main
    int win;
    int expv;
    int f;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(OFS_PRESCALE, PRESCALE_RST);
    rd_reg(OFS_DUTY, DUTY_RST);
    wr_reg(OFS_DUTY, 8'h5a);
    rd_reg(OFS_DUTY, 8'h5a);
    wr_reg(OFS_STATUS, 8'h77);
    rd_reg(OFS_STATUS, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr_reg(OFS_CONTROL, 8'h00);
      wr_reg(OFS_PRESCALE, psc[i]);
      wr_reg(OFS_DUTY, duty[i]);
      wr_reg(OFS_CONTROL, {6'h00, ctl[i]});
      // Fast window spans three periods so tick jitter averages out
      f = int'(psc[i][6:0]) + 1;
      win = (psc[i][7] ? 51200 : 1280) * f;
      expv = (psc[i][7] ? 200 : 5) * int'(duty[i]) * f;
      if (duty[i] == 8'hff) expv = win;
      if (ctl[i][1]) expv = win - expv;
      if (!ctl[i][0]) expv = 0;
      repeat (8) @(posedge clk);
      meas(win, 32'(expv));
    end
    wr_reg(OFS_CONTROL, 8'h00);
    rd_reg(OFS_STATUS, 8'h00);
    chk("fan_drive_out", 32'(fan), 32'h0);
    end_of_test();
  end
endmodule
